// file: flash_guard_regs.svh
`ifndef FLASH_GUARD_REGS_SVH
`define FLASH_GUARD_REGS_SVH

// Status word bit positions
`define SR_BUSY_POS        0
`define SR_WEL_POS         1
`define SR_LOCK_LSB        10
`define SR_LOCK_MSB        13
`define SR_PAUSED_POS      15
`define SR_RESET_VALUE     16'h0000

// Guard mode encodings {reg_guard_hi, reg_guard_lo}
`define GUARD_SOFTWARE     2'h0
`define GUARD_PIN          2'h1
`define GUARD_SUPPLY_LOCK  2'h2
`define GUARD_OTP          2'h3

// Instruction codes
`define OP_WRITE_ENABLE    8'h06
`define OP_WRITE_DISABLE   8'h04
`define OP_READ_STATUS_LO  8'h05
`define OP_READ_STATUS_HI  8'h35
`define OP_WRITE_STATUS    8'h01
`define OP_PAGE_PROGRAM    8'h02
`define OP_QUAD_PROGRAM    8'h32
`define OP_SECTOR_ERASE    8'h20
`define OP_BLOCK_ERASE_32  8'h52
`define OP_BLOCK_ERASE_64  8'hD8
`define OP_CHIP_ERASE_A    8'hC7
`define OP_CHIP_ERASE_B    8'h60
`define OP_SEC_REG_ERASE   8'h44
`define OP_SEC_REG_PROGRAM 8'h42
`define OP_SUSPEND         8'h75
`define OP_RESUME          8'h7A
`define OP_POWER_DOWN      8'hB9
`define OP_RELEASE_PD      8'hAB

// Timing
`define CLK_PERIOD_NS      50
`define PUW_TIME_NS        10000
`define PUW_CYCLES         ((`PUW_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_TIME_NS       5000
`define BUSY_CYCLES        ((`BUSY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: flash_guard_pkg.sv
package flash_guard_pkg;

    typedef struct packed {
        logic       paused_flag;
        logic       invert_protection;
        logic [3:0] otp_region_lock;
        logic       four_lane_enable;
        logic       reg_guard_hi;
        logic       reg_guard_lo;
        logic       small_unit_select;
        logic       bottom_side_select;
        logic [2:0] guard_size;
        logic       write_latch_flag;
        logic       busy_flag;
    } protection_state_word_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
    } op_start_t;

endpackage

// file: flash_write_protect_status.sv
// How it works
// R1: During power-on reset nothing runs and no serial instruction is recognised.
// R2: After reset, write-type instructions stay refused for a fixed power-up delay.
// R3: After power-up the write latch reads 0.
// R4: Program, erase and status write need the write latch set first.
// R5: Write disable, program, erase, status write and security ops clear the latch; here refused status writes and paused program/erase keep it.
// R6: Write latch is read-only bit S1, set by write enable.
// R7: In power-down every instruction except release power-down is ignored.
// R8: Busy bit S0 reads 1 while a program, erase or status write runs.
// R9: While busy, only status reads and suspend are honoured.
// R10: Block-protect size field S4..S2 defaults to 0, written by status write.
// R11: Bottom-side select anchors protection at top when 0, bottom when 1.
// R12: Small-unit select counts 4KB sectors when 1, 64KB blocks when 0.
// R13: Invert-protection bit S14 complements the selected protection.
// R14: Guard bits 00: protect pin ignored, status write needs only the latch.
// R15: Guard bits 01: status write refused while protect pin is low.
// R16: Guard bits 10: status writes refused until power cycle, which restores 00.
// R17: Guard bits 11: status writes refused permanently.
// R18: Protect pin gates status writes only when four-lane mode is off.
// R19: Paused flag S15 set by suspend 75h, cleared by resume 7Ah or power cycle.
// R20: Lock bits S13..S10 set by status write and never clear again.
// R21: Four-lane enable bit S9 turns protect and hold pins into data lanes.
// R22: The power-on reset input is the power cycle for all volatile state.
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_regs.svh"
module flash_write_protect_status
(
    input  wire logic                                   clk_sys_in,
    input  wire logic                                   rst_b_in,
    input  wire logic                                   cs_b_in,
    input  wire logic                                   sclk_in,
    input  wire logic                                   di_in,
    input  wire logic                                   wp_b_in,
    input  wire logic [15:0]                            nv_image_in,
    output logic                                        do_out,
    output logic                                        do_oe_out,
    output flash_guard_pkg::protection_state_word_t     status_out,
    output logic [15:0]                                 nv_image_out,
    output flash_guard_pkg::op_start_t                  op_start_out,
    output logic                                        power_down_out
);

    // Pin synchronisers
    logic       cs_s1_ff, cs_s2_ff, cs_s3_ff;
    logic       sck_s1_ff, sck_s2_ff, sck_s3_ff;
    logic       di_s1_ff, di_s2_ff;
    logic       wp_s1_ff, wp_s2_ff;

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cs_s1_ff  <= 1'b1;
            cs_s2_ff  <= 1'b1;
            cs_s3_ff  <= 1'b1;
            sck_s1_ff <= 1'b0;
            sck_s2_ff <= 1'b0;
            sck_s3_ff <= 1'b0;
            di_s1_ff  <= 1'b0;
            di_s2_ff  <= 1'b0;
            wp_s1_ff  <= 1'b0;
            wp_s2_ff  <= 1'b0;
        end
        else
        begin
            cs_s1_ff  <= cs_b_in;
            cs_s2_ff  <= cs_s1_ff;
            cs_s3_ff  <= cs_s2_ff;
            sck_s1_ff <= sclk_in;
            sck_s2_ff <= sck_s1_ff;
            sck_s3_ff <= sck_s2_ff;
            di_s1_ff  <= di_in;
            di_s2_ff  <= di_s1_ff;
            wp_s1_ff  <= wp_b_in;
            wp_s2_ff  <= wp_s1_ff;
        end
    end

    // Serial frame state
    logic       armed_ff, nxt_armed;
    logic [2:0] bit_cnt_ff, nxt_bit_cnt;
    logic [1:0] byte_cnt_ff, nxt_byte_cnt;
    logic [6:0] shift_ff, nxt_shift;
    logic [7:0] opcode_ff, nxt_opcode;
    logic [7:0] data0_ff, nxt_data0;
    logic [7:0] data1_ff, nxt_data1;
    logic       do_ff, nxt_do;
    logic       do_oe_ff, nxt_do_oe;

    // Protection state
    flash_guard_pkg::protection_state_word_t sr_ff, nxt_sr;
    logic       loaded_ff, nxt_loaded;
    logic [7:0] puw_cnt_ff, nxt_puw_cnt;
    logic       run_ff, nxt_run;
    logic [7:0] busy_cnt_ff, nxt_busy_cnt;
    logic       pd_ff, nxt_pd;
    flash_guard_pkg::op_start_t start_ff, nxt_start;

    logic       sck_rise;
    logic       sck_fall;
    logic       selected;
    logic       frame_end;
    logic       whole_frame;
    logic [7:0] new_byte;
    logic [7:0] status_byte;
    logic       reading;
    logic       puw_done;
    logic       sr_write_ok;
    logic       is_prog_erase;

    assign sck_rise    = sck_s2_ff & ~sck_s3_ff;
    assign sck_fall    = ~sck_s2_ff & sck_s3_ff;
    // Selection needs a high-to-low of chip select after reset
    assign selected    = ~cs_s2_ff & armed_ff; // R1
    assign frame_end   = cs_s2_ff & ~cs_s3_ff & armed_ff;
    assign whole_frame = (bit_cnt_ff == 3'h0) && (byte_cnt_ff != 2'h0);
    assign new_byte    = {shift_ff, di_s2_ff};
    assign status_byte = (opcode_ff == `OP_READ_STATUS_HI) ? sr_ff[15:8] : sr_ff[7:0];
    assign reading     = (byte_cnt_ff != 2'h0) && !pd_ff && // R7
                         ((opcode_ff == `OP_READ_STATUS_LO) || (opcode_ff == `OP_READ_STATUS_HI));
    assign puw_done    = (puw_cnt_ff == 8'h00);
    assign is_prog_erase = (opcode_ff == `OP_PAGE_PROGRAM) || (opcode_ff == `OP_QUAD_PROGRAM) ||
                           (opcode_ff == `OP_SECTOR_ERASE) || (opcode_ff == `OP_BLOCK_ERASE_32) ||
                           (opcode_ff == `OP_BLOCK_ERASE_64) || (opcode_ff == `OP_CHIP_ERASE_A) ||
                           (opcode_ff == `OP_CHIP_ERASE_B) || (opcode_ff == `OP_SEC_REG_ERASE) ||
                           (opcode_ff == `OP_SEC_REG_PROGRAM);

    always_comb
    begin
        case ({sr_ff.reg_guard_hi, sr_ff.reg_guard_lo})
            `GUARD_SOFTWARE:    sr_write_ok = 1'b1; // R14
            `GUARD_PIN:         sr_write_ok = sr_ff.four_lane_enable | wp_s2_ff; // R15 R18 R21
            `GUARD_SUPPLY_LOCK: sr_write_ok = 1'b0; // R16
            `GUARD_OTP:         sr_write_ok = 1'b0; // R17
            default:            sr_write_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        nxt_armed    = armed_ff | (cs_s2_ff & loaded_ff);
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_byte_cnt = byte_cnt_ff;
        nxt_shift    = shift_ff;
        nxt_opcode   = opcode_ff;
        nxt_data0    = data0_ff;
        nxt_data1    = data1_ff;
        nxt_do       = do_ff;
        nxt_do_oe    = do_oe_ff;
        if (!selected)
        begin
            nxt_bit_cnt  = 3'h0;
            nxt_byte_cnt = 2'h0;
            nxt_do_oe    = 1'b0;
        end
        else
        begin
            if (sck_rise)
            begin
                nxt_shift   = new_byte[6:0];
                nxt_bit_cnt = bit_cnt_ff + 3'h1;
                if (bit_cnt_ff == 3'h7)
                begin
                    if (byte_cnt_ff != 2'h3)
                        nxt_byte_cnt = byte_cnt_ff + 2'h1;
                    case (byte_cnt_ff)
                        2'h0:    nxt_opcode = new_byte;
                        2'h1:    nxt_data0  = new_byte;
                        2'h2:    nxt_data1  = new_byte;
                        default: nxt_data1  = data1_ff;
                    endcase
                end
            end
            if (sck_fall)
            begin
                nxt_do    = status_byte[~bit_cnt_ff];
                nxt_do_oe = reading;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            armed_ff    <= 1'b0;
            bit_cnt_ff  <= 3'h0;
            byte_cnt_ff <= 2'h0;
            shift_ff    <= 7'h00;
            opcode_ff   <= 8'h00;
            data0_ff    <= 8'h00;
            data1_ff    <= 8'h00;
            do_ff       <= 1'b0;
            do_oe_ff    <= 1'b0;
        end
        else
        begin
            armed_ff    <= nxt_armed;
            bit_cnt_ff  <= nxt_bit_cnt;
            byte_cnt_ff <= nxt_byte_cnt;
            shift_ff    <= nxt_shift;
            opcode_ff   <= nxt_opcode;
            data0_ff    <= nxt_data0;
            data1_ff    <= nxt_data1;
            do_ff       <= nxt_do;
            do_oe_ff    <= nxt_do_oe;
        end
    end

    always_comb
    begin
        nxt_sr       = sr_ff;
        nxt_loaded   = 1'b1;
        nxt_puw_cnt  = puw_cnt_ff;
        nxt_run      = run_ff;
        nxt_busy_cnt = busy_cnt_ff;
        nxt_pd       = pd_ff;
        nxt_start    = '0;
        if (!loaded_ff)
        begin
            // Non-volatile bits come from storage, volatile ones start cleared
            nxt_sr = nv_image_in;
            nxt_sr.paused_flag      = 1'b0; // R19 R22
            nxt_sr.write_latch_flag = 1'b0; // R3
            nxt_sr.busy_flag        = 1'b0;
            if ({nxt_sr.reg_guard_hi, nxt_sr.reg_guard_lo} == `GUARD_SUPPLY_LOCK)
            begin
                nxt_sr.reg_guard_hi = 1'b0; // R16 R22
                nxt_sr.reg_guard_lo = 1'b0;
            end
            nxt_puw_cnt = 8'(`PUW_CYCLES); // R2
        end
        else
        begin
            if (!puw_done)
                nxt_puw_cnt = puw_cnt_ff - 8'h01;
            if (run_ff && !sr_ff.paused_flag)
            begin
                nxt_busy_cnt = busy_cnt_ff - 8'h01;
                if (busy_cnt_ff == 8'h01)
                    nxt_run = 1'b0;
            end
            if (frame_end && whole_frame)
            begin
                if (pd_ff)
                begin
                    if (opcode_ff == `OP_RELEASE_PD)
                        nxt_pd = 1'b0; // R7
                end
                else if (sr_ff.busy_flag)
                begin
                    if (opcode_ff == `OP_SUSPEND)
                        nxt_sr.paused_flag = 1'b1; // R9 R19
                end
                else
                begin
                    case (opcode_ff)
                        `OP_WRITE_ENABLE:
                            if (puw_done)
                                nxt_sr.write_latch_flag = 1'b1; // R2 R6
                        `OP_WRITE_DISABLE:
                            nxt_sr.write_latch_flag = 1'b0; // R5
                        `OP_POWER_DOWN:
                            nxt_pd = 1'b1;
                        `OP_RESUME:
                            nxt_sr.paused_flag = 1'b0; // R19
                        `OP_WRITE_STATUS:
                            if (sr_ff.write_latch_flag && puw_done && sr_write_ok) // R4 R14
                            begin
                                nxt_sr.reg_guard_lo       = data0_ff[7];
                                nxt_sr.small_unit_select  = data0_ff[6]; // R12
                                nxt_sr.bottom_side_select = data0_ff[5]; // R11
                                nxt_sr.guard_size         = data0_ff[4:2]; // R10
                                if (byte_cnt_ff == 2'h3)
                                begin
                                    nxt_sr.invert_protection = data1_ff[6]; // R13
                                    nxt_sr.otp_region_lock   = sr_ff.otp_region_lock | data1_ff[5:2]; // R20
                                    nxt_sr.four_lane_enable  = data1_ff[1]; // R21
                                    nxt_sr.reg_guard_hi      = data1_ff[0];
                                end
                                nxt_sr.write_latch_flag = 1'b0; // R5
                                nxt_run      = 1'b1; // R8
                                nxt_busy_cnt = 8'(`BUSY_CYCLES);
                            end
                        default:
                            if (is_prog_erase && sr_ff.write_latch_flag && puw_done && !sr_ff.paused_flag) // R4
                            begin
                                nxt_sr.write_latch_flag = 1'b0; // R5
                                nxt_run          = 1'b1; // R8
                                nxt_busy_cnt     = 8'(`BUSY_CYCLES);
                                nxt_start.valid  = 1'b1;
                                nxt_start.opcode = opcode_ff;
                            end
                    endcase
                end
            end
        end
        nxt_sr.busy_flag = nxt_run & ~nxt_sr.paused_flag; // R8
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sr_ff       <= `SR_RESET_VALUE;
            loaded_ff   <= 1'b0;
            puw_cnt_ff  <= 8'h00;
            run_ff      <= 1'b0;
            busy_cnt_ff <= 8'h00;
            pd_ff       <= 1'b0;
            start_ff    <= '0;
        end
        else
        begin
            sr_ff       <= nxt_sr;
            loaded_ff   <= nxt_loaded;
            puw_cnt_ff  <= nxt_puw_cnt;
            run_ff      <= nxt_run;
            busy_cnt_ff <= nxt_busy_cnt;
            pd_ff       <= nxt_pd;
            start_ff    <= nxt_start;
        end
    end

    assign do_out         = do_ff;
    assign do_oe_out      = do_oe_ff;
    assign status_out     = sr_ff;
    assign nv_image_out   = {1'b0, sr_ff[14:2], 2'h0};
    assign op_start_out   = start_ff;
    assign power_down_out = pd_ff;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_status_write_end;
        frame_end && whole_frame && !pd_ff && !sr_ff.busy_flag && (opcode_ff == `OP_WRITE_STATUS);
    endsequence
    sequence s_busy_run;
        sr_ff.busy_flag [*8];
    endsequence

    property p_puw_latch;
        loaded_ff && !puw_done |-> !sr_ff.write_latch_flag;
    endproperty
    a_puw_latch: assert property (p_puw_latch) else $error("latch set inside power-up delay"); // R2
    property p_powerup_latch;
        $rose(loaded_ff) |-> !sr_ff.write_latch_flag && !sr_ff.paused_flag;
    endproperty
    a_powerup_latch: assert property (p_powerup_latch) else $error("volatile bits not clear at power-up"); // R3
    property p_start_needs_latch;
        start_ff.valid |-> $past(sr_ff.write_latch_flag) && !sr_ff.write_latch_flag;
    endproperty
    a_start_needs_latch: assert property (p_start_needs_latch) else $error("operation without latch"); // R4
    property p_start_busy;
        start_ff.valid |-> s_busy_run;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy did not hold after start"); // R8
    property p_busy_no_latch;
        $rose(sr_ff.write_latch_flag) |-> !$past(sr_ff.busy_flag) && !$past(pd_ff);
    endproperty
    a_busy_no_latch: assert property (p_busy_no_latch) else $error("latch set while busy or powered down"); // R9
    property p_guard_locked;
        s_status_write_end and sr_ff.reg_guard_hi |=> $stable(sr_ff[14:2]);
    endproperty
    a_guard_locked: assert property (p_guard_locked) else $error("status written while locked"); // R16
    property p_pin_guard;
        s_status_write_end and (!sr_ff.reg_guard_hi && sr_ff.reg_guard_lo
            && !sr_ff.four_lane_enable && !wp_s2_ff) |=> $stable(sr_ff[14:2]);
    endproperty
    a_pin_guard: assert property (p_pin_guard) else $error("status written with pin low"); // R15
    property p_lock_sticky;
        loaded_ff && $past(loaded_ff) |-> ((sr_ff.otp_region_lock & $past(sr_ff.otp_region_lock))
            == $past(sr_ff.otp_region_lock));
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared"); // R20
    property p_pause_cause;
        $rose(sr_ff.paused_flag) |-> $past(frame_end) && $past(sr_ff.busy_flag) && ($past(opcode_ff) == `OP_SUSPEND);
    endproperty
    a_pause_cause: assert property (p_pause_cause) else $error("paused without suspend"); // R19

endmodule // flash_write_protect_status
`default_nettype wire

// file: flash_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_host_model
(
    input  wire logic clk_sys_in,
    input  wire logic do_in,
    output logic      cs_b_out,
    output logic      sclk_out,
    output logic      di_out
);
    localparam int HALF = 4;

    initial
    begin
        cs_b_out = 1'b1;
        sclk_out = 1'b0;
        di_out   = 1'b1;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    // Mode 0 frame: opcode, data bytes low first, then rbits clocks of read-back
    task automatic xfer(input logic [7:0] op, input int nbytes, input logic [15:0] data,
                        input int rbits, output logic [7:0] rd);
        logic [23:0] sh;
        int          nw;
        sh = {op, data[7:0], data[15:8]};
        nw = 8 * (nbytes + 1);
        rd = 8'h00;
        ticks(1);
        cs_b_out <= 1'b0;
        for (int i = 0; i < nw + rbits; i++)
        begin
            if (i < nw)
                di_out <= sh[23 - i];
            else
                di_out <= ~di_out;
            ticks(HALF);
            sclk_out <= 1'b1;
            ticks(HALF);
            // Read bit was launched on the previous fall, so it is settled here
            if (i >= nw)
                rd = {rd[6:0], do_in};
            sclk_out <= 1'b0;
        end
        ticks(HALF);
        cs_b_out <= 1'b1;
        // Released data line must not keep showing the last bit
        di_out   <= ~di_out;
        ticks(8);
    endtask
endmodule // flash_host_model
`default_nettype wire

// file: test_flash_write_protect_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_regs.svh"
module test_flash_write_protect_status;
    logic                                    clk_sys_in  = 1'b0;
    logic                                    rst_b_in    = 1'b0;
    logic                                    wp_b_in     = 1'b1;
    logic [15:0]                             nv_image_in = 16'h4114;
    logic                                    cs_b;
    logic                                    sclk;
    logic                                    di;
    logic                                    do_out;
    logic                                    do_oe_out;
    logic                                    do_line;
    logic                                    noise       = 1'b0;
    logic                                    power_down_out;
    logic [15:0]                             nv_image_out;
    flash_guard_pkg::protection_state_word_t status_out;
    flash_guard_pkg::op_start_t              op_start_out;
    int                                      err_count   = 0;
    int                                      n_compared  = 0;
    int                                      n_starts    = 0;
    logic [7:0]                              last_op     = 8'h00;
    logic [7:0]                              rd;
    logic [7:0]                              ops [9]     = '{`OP_PAGE_PROGRAM, `OP_QUAD_PROGRAM, `OP_SECTOR_ERASE,
        `OP_BLOCK_ERASE_32, `OP_BLOCK_ERASE_64, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B, `OP_SEC_REG_ERASE, `OP_SEC_REG_PROGRAM};

    always #(`CLK_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) noise <= ~noise;
    // Undriven output line floats: show a changing pattern instead of the last bit
    assign do_line = do_oe_out ? do_out : noise;
    always @(posedge clk_sys_in)
    begin
        if (op_start_out.valid === 1'b1)
        begin
            n_starts++;
            last_op = op_start_out.opcode;
        end
    end

    flash_write_protect_status dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b), .sclk_in(sclk),
        .di_in(di), .wp_b_in(wp_b_in), .nv_image_in(nv_image_in), .do_out(do_out), .do_oe_out(do_oe_out),
        .status_out(status_out), .nv_image_out(nv_image_out), .op_start_out(op_start_out),
        .power_down_out(power_down_out));
    flash_host_model host (.clk_sys_in(clk_sys_in), .do_in(do_line), .cs_b_out(cs_b), .sclk_out(sclk), .di_out(di));

    task automatic summarize;
        if (err_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic cmd(input logic [7:0] op, input int nb = 0, input logic [15:0] d = 16'h0000);
        host.xfer(op, nb, d, 0, rd);
    endtask

    task automatic wait_idle;
        int i;
        for (i = 0; i < 400 && status_out.busy_flag !== 1'b0; i++)
            ticks(1);
        if (i == 400)
        begin
            err_count++;
            $display("unexpected busy wait: expected 0, seen 1");
            summarize();
        end
    endtask

    task automatic wsr(input logic [15:0] d, input int nb = 2);
        cmd(`OP_WRITE_ENABLE);
        cmd(`OP_WRITE_STATUS, nb, d);
        wait_idle();
    endtask

    task automatic do_reset(input logic [15:0] nv, input logic [15:0] exp);
        nv_image_in <= nv;
        rst_b_in    <= 1'b0;
        ticks(12);
        rst_b_in <= 1'b1;
        ticks(3);
        chk("status after power cycle", exp, status_out);
        ticks(`PUW_CYCLES);
    endtask

    task automatic s_power_up;
        ticks(2);
        chk("status in reset", 16'h0000, status_out);
        chk("power down in reset", 16'h0000, {15'h0000, power_down_out});
        ticks(10);
        rst_b_in <= 1'b1;
        ticks(3);
        chk("status after load", 16'h4014, status_out);
        cmd(`OP_WRITE_ENABLE);
        chk("latch in power-up delay", 16'h4014, status_out);
        ticks(`PUW_CYCLES);
        cmd(`OP_WRITE_ENABLE);
        chk("latch after write enable", 16'h4016, status_out);
    endtask

    task automatic s_power_down;
        host.xfer(`OP_READ_STATUS_LO, 0, 16'h0000, 8, rd);
        chk("status low read", 16'h0016, {8'h00, rd});
        host.xfer(`OP_READ_STATUS_HI, 0, 16'h0000, 8, rd);
        chk("status high read", 16'h0040, {8'h00, rd});
        cmd(`OP_WRITE_DISABLE);
        chk("latch after write disable", 16'h4014, status_out);
        cmd(`OP_POWER_DOWN);
        chk("power down", 16'h0001, {15'h0000, power_down_out});
        cmd(`OP_WRITE_ENABLE);
        cmd(`OP_RELEASE_PD);
        chk("power down released", 16'h0000, {15'h0000, power_down_out});
        chk("latch ignored in power down", 16'h4014, status_out);
    endtask

    task automatic s_status_write;
        cmd(`OP_WRITE_STATUS, 2, 16'h0478);
        chk("status write without latch", 16'h4014, status_out);
        cmd(`OP_WRITE_ENABLE);
        cmd(`OP_WRITE_STATUS, 2, 16'h0478);
        chk("latch and busy", 16'h0001, 16'(status_out[1:0]));
        cmd(`OP_WRITE_ENABLE);
        chk("write enable while busy", 16'h0001, 16'(status_out[1:0]));
        wait_idle();
        chk("status written", 16'h0478, status_out);
        chk("stored image", 16'h0478, nv_image_out);
        wsr(16'h4000);
        chk("lock kept, invert set", 16'h4400, status_out);
        wsr(16'h007F, 1);
        chk("low byte write", 16'h447C, status_out);
    endtask

    task automatic s_guard;
        wsr(16'h0080);
        chk("pin guard set", 16'h0480, status_out);
        wp_b_in <= 1'b0;
        wsr(16'h0084);
        chk("pin low refuses", 16'h0482, status_out);
        wp_b_in <= 1'b1;
        wsr(16'h0280);
        chk("pin high accepts", 16'h0680, status_out);
        wp_b_in <= 1'b0;
        wsr(16'h0288);
        chk("four lane ignores pin", 16'h0688, status_out);
        wsr(16'h0100);
        chk("lock-down set", 16'h0500, status_out);
        wp_b_in <= 1'b1;
        wsr(16'h0000);
        chk("lock-down refuses", 16'h0502, status_out);
        do_reset(16'h0500, 16'h0400);
        wsr(16'h0000);
        chk("write after power cycle", 16'h0400, status_out);
        do_reset(16'h0180, 16'h0180);
        wsr(16'h0000);
        chk("permanent guard refuses", 16'h0182, status_out);
        do_reset(16'h0000, 16'h0000);
    endtask

    task automatic s_program;
        int n0;
        n0 = n_starts;
        cmd(`OP_PAGE_PROGRAM);
        chk("program without latch", 16'(n0), 16'(n_starts));
        foreach (ops[i])
        begin
            cmd(`OP_WRITE_ENABLE);
            cmd(ops[i]);
            chk("start opcode", {8'h00, ops[i]}, {8'h00, last_op});
            chk("latch and busy", 16'h0001, 16'(status_out[1:0]));
            wait_idle();
        end
        chk("start count", 16'(n0 + 9), 16'(n_starts));
        cmd(`OP_WRITE_ENABLE);
        cmd(`OP_PAGE_PROGRAM);
        cmd(`OP_SUSPEND);
        chk("paused and busy", 16'h0002, {14'h0000, status_out.paused_flag, status_out.busy_flag});
        cmd(`OP_WRITE_ENABLE);
        cmd(`OP_PAGE_PROGRAM);
        chk("program while paused", 16'(n0 + 10), 16'(n_starts));
        cmd(`OP_RESUME);
        chk("resumed", 16'h0001, {14'h0000, status_out.paused_flag, status_out.busy_flag});
        wait_idle();
        cmd(`OP_WRITE_ENABLE);
        cmd(`OP_SECTOR_ERASE);
        cmd(`OP_SUSPEND);
        chk("paused before power cycle", 16'h8000, status_out);
        do_reset(16'h0000, 16'h0000);
    endtask

    initial
    begin
        s_power_up();
        s_power_down();
        s_status_write();
        s_guard();
        s_program();
        summarize();
    end
endmodule // test_flash_write_protect_status
`default_nettype wire
